// *** hdl/exp_param_store.sv ***
`timescale 1ns/1ps
`default_nettype none
module exp_param_store
    import trig_exp_pkg::*;
(
    input  wire logic             ref_clk,     // Core clock
    input  wire logic             sys_rst,     // Sync reset
    input  wire logic             nv_valid,    // Stored value present
    input  wire logic [EXP_W-1:0] nv_exp,      // Stored exposure cycles
    input  wire logic             cfg_we,      // Host write strobe
    input  wire logic [EXP_W-1:0] cfg_exp,     // Host exposure cycles
    input  wire logic             save_req,    // Persist request pulse
    output logic                  nv_we,       // Write to non-volatile store
    output logic      [EXP_W-1:0] nv_wdata,    // Data for non-volatile store
    output logic      [EXP_W-1:0] exp_live     // Current exposure setting
);
    logic [EXP_W-1:0] exp_r, exp_nxt, wd_r, wd_nxt;
    logic             ld_r, ld_nxt, we_r, we_nxt;

    always_comb
    begin
        exp_nxt = exp_r;
        ld_nxt  = 1'b1;
        we_nxt  = save_req;
        wd_nxt  = save_req ? exp_r : wd_r;
        // Restore only in the first cycle after reset, a host write always wins
        if (!ld_r && nv_valid)
            exp_nxt = clamp_exp(nv_exp);
        if (cfg_we)
            exp_nxt = clamp_exp(cfg_exp);
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            exp_r <= EXP_RESET;
            ld_r  <= 1'b0;
            we_r  <= 1'b0;
            wd_r  <= '0;
        end
        else
        begin
            exp_r <= exp_nxt;
            ld_r  <= ld_nxt;
            we_r  <= we_nxt;
            wd_r  <= wd_nxt;
        end
    end

    assign exp_live = exp_r;
    assign nv_we    = we_r;
    assign nv_wdata = wd_r;

    write_immediate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cfg_we |=> exp_live == clamp_exp($past(cfg_exp))) else $error("host write not applied");
    span_kept_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        exp_live >= EXP_W'(EXP_MIN_CYC)) else $error("exposure below minimum");
endmodule
`default_nettype wire

// *** hdl/trig_edge_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module trig_edge_sync
    import trig_exp_pkg::*;
(
    input  wire logic                ref_clk,  // Core clock
    input  wire logic                sys_rst,  // Sync reset
    input  wire logic [IN_COUNT-1:0] pins_in,  // Async trigger pins
    output logic      [IN_COUNT-1:0] level,    // Filtered levels
    output logic      [IN_COUNT-1:0] rise      // One-cycle rising pulse
);
    logic [IN_COUNT-1:0] s1_r, s2_r, s3_r, lvl_r;
    logic [IN_COUNT-1:0] lvl_nxt, rise_nxt, rise_r;

    always_comb
    begin
        lvl_nxt  = lvl_r;
        rise_nxt = '0;
        for (int i = 0; i < IN_COUNT; i++)
        begin
            // Accept a change only once stages two and three agree
            if (s2_r[i] == s3_r[i] && s3_r[i] != lvl_r[i])
            begin
                lvl_nxt[i]  = s3_r[i];
                rise_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            s1_r   <= '0;
            s2_r   <= '0;
            s3_r   <= '0;
            lvl_r  <= '0;
            rise_r <= '0;
        end
        else
        begin
            s1_r   <= pins_in;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            lvl_r  <= lvl_nxt;
            rise_r <= rise_nxt;
        end
    end

    assign level = lvl_r;
    assign rise  = rise_r;

    single_pulse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        |rise |=> ~|(rise & $past(rise))) else $error("rise pulse longer than one cycle");
endmodule
`default_nettype wire

// *** hdl/trig_exp_pkg.sv ***
package trig_exp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS     = 100;
    localparam int unsigned EXP_MIN_US        = 60;
    localparam int unsigned EXP_MAX_S         = 60;
    localparam int unsigned EXP_MIN_CYC       = (EXP_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam longint unsigned EXP_MAX_CYC   = (64'(EXP_MAX_S) * 64'd1000000000) / 64'(CLK_PERIOD_NS);
    localparam int unsigned EXP_W             = 32;
    localparam logic [EXP_W-1:0] EXP_RESET    = EXP_W'(EXP_MIN_CYC);
    localparam int unsigned START_DELAY_NS    = 1000;
    localparam int unsigned START_DELAY_CYC   = START_DELAY_NS / CLK_PERIOD_NS;
    localparam int unsigned DLY_W             = 8;
    localparam int unsigned TIMER_W           = 32;
    localparam logic [TIMER_W-1:0] TIMER_RESET = 32'h000f_4240;

    ////////////////////////////////////////////////////////////////////////////
    // Source and input selection
    localparam int unsigned IN_COUNT = 4;
    localparam int unsigned IN_SEL_W = 2;
    localparam logic [IN_SEL_W-1:0] IN_SEL_RESET = 2'h0;

    typedef enum logic [1:0]
    {
        SRC_SOFTWARE,
        SRC_HARDWARE,
        SRC_TIMED
    } trig_src_type;

    localparam trig_src_type SRC_RESET = SRC_HARDWARE;

    // Clamp an exposure request into the supported span
    function automatic logic [EXP_W-1:0] clamp_exp(input logic [EXP_W-1:0] v);
        logic [EXP_W-1:0] r;
        r = v;
        if (v < EXP_W'(EXP_MIN_CYC))
            r = EXP_W'(EXP_MIN_CYC);
        else if (64'(v) > EXP_MAX_CYC)
            r = EXP_W'(EXP_MAX_CYC);
        return r;
    endfunction

endpackage

// *** hdl/trigger_exposure_control.sv ***
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - No capture without a trigger event
// - Software, hardware or timed trigger source
// - External pulse starts programmed-length exposure
// - Hardware source defaults to input one
// - Exposure starts on trigger rising edge
// - Exposure span covers 60us to 60s
// - Readout trigger aligns to line-valid fall
// - Idle trigger starts after fixed delay
// - Live exposure change, no corrupted frame
// - Restore stored exposure after power cycle
// - Setting changes apply immediately
module trigger_exposure_control
    import trig_exp_pkg::*;
(
    input  wire logic                ref_clk,        // Core clock, 10 MHz
    input  wire logic                sys_rst,        // Sync reset, active high
    input  wire logic [IN_COUNT-1:0] trigger_in,     // Trigger pins, index 0 is trigger_input_one
    input  wire logic                sw_trigger,     // Software trigger pulse
    input  wire logic [1:0]          src_sel,        // Trigger source select
    input  wire logic                src_we,         // Source select write strobe
    input  wire logic [IN_SEL_W-1:0] in_sel,         // Hardware input select
    input  wire logic                in_sel_we,      // Input select write strobe
    input  wire logic [TIMER_W-1:0]  timer_period,   // Timed trigger period cycles
    input  wire logic                timer_we,       // Period write strobe
    input  wire logic                acq_enable,     // Acquisition enabled level
    input  wire logic [EXP_W-1:0]    cfg_exp,        // Exposure time in cycles
    input  wire logic                cfg_exp_we,     // Exposure write strobe
    input  wire logic                save_req,       // Persist configuration pulse
    input  wire logic                nv_valid,       // Stored exposure present
    input  wire logic [EXP_W-1:0]    nv_exp,         // Stored exposure value
    input  wire logic                frame_valid,    // Sensor frame valid
    input  wire logic                line_valid,     // Sensor line valid
    output logic                     nv_we,          // Persist write pulse
    output logic      [EXP_W-1:0]    nv_wdata,       // Persist data
    output logic                     exposure_active,// Sensor integrating
    output logic                     exposure_start, // Integration start pulse
    output logic                     exposure_end,   // Integration end pulse
    output logic                     waiting_trigger // Armed and idle
);
    typedef enum logic [1:0] {ST_IDLE, ST_ALIGN, ST_DELAY, ST_EXPOSE} st_type;

    logic [IN_COUNT-1:0] hw_level, hw_rise;
    logic [EXP_W-1:0]    exp_live;

    ////////////////////////////////////////////////////////////////////////////
    // Hardware inputs pass the triple-stage synchroniser
    trig_edge_sync u_sync
    (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pins_in (trigger_in),
        .level   (hw_level),
        .rise    (hw_rise)
    );

    exp_param_store u_store
    (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .nv_valid (nv_valid),
        .nv_exp   (nv_exp),
        .cfg_we   (cfg_exp_we),
        .cfg_exp  (cfg_exp),
        .save_req (save_req),
        .nv_we    (nv_we),
        .nv_wdata (nv_wdata),
        .exp_live (exp_live)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Configuration
    trig_src_type        src_r, src_nxt;
    logic [IN_SEL_W-1:0] insel_r, insel_nxt;
    logic [TIMER_W-1:0]  per_r, per_nxt;

    always_comb
    begin
        src_nxt   = src_r;
        insel_nxt = insel_r;
        per_nxt   = per_r;
        // Code 3 is reserved; dropping it keeps the source legal
        if (src_we && src_sel != 2'h3)
            src_nxt = trig_src_type'(src_sel);
        if (in_sel_we)
            insel_nxt = in_sel;
        if (timer_we)
            per_nxt = (timer_period == '0) ? TIMER_W'(1) : timer_period;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            src_r   <= SRC_RESET;
            insel_r <= IN_SEL_RESET;
            per_r   <= TIMER_RESET;
        end
        else
        begin
            src_r   <= src_nxt;
            insel_r <= insel_nxt;
            per_r   <= per_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timed trigger source; free-running while timed source is chosen and acquisition is enabled
    logic [TIMER_W-1:0] tmr_r, tmr_nxt;
    logic               tmr_hit;

    // Restarts from zero when deselected, so the first shot is a full period out
    always_comb
    begin
        tmr_hit = 1'b0;
        tmr_nxt = '0;
        if (src_r == SRC_TIMED && acq_enable)
        begin
            if (tmr_r + TIMER_W'(1) >= per_r)
                tmr_hit = 1'b1;
            else
                tmr_nxt = tmr_r + TIMER_W'(1);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            tmr_r <= '0;
        else
            tmr_r <= tmr_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trigger merge
    logic trig_ev;

    always_comb
    begin
        case (src_r)
            SRC_SOFTWARE: trig_ev = sw_trigger;
            SRC_HARDWARE: trig_ev = hw_rise[insel_r];
            SRC_TIMED:    trig_ev = tmr_hit;
            default:      trig_ev = 1'b0;
        endcase
        trig_ev = trig_ev & acq_enable;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line-valid fall detect (same-clock sensor timing)
    logic lv_d_r, lv_fall;

    // Reset low like an idle line, so no false fall after reset
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            lv_d_r <= 1'b0;
        else
            lv_d_r <= line_valid;
    end

    assign lv_fall = lv_d_r & ~line_valid;

    ////////////////////////////////////////////////////////////////////////////
    // Exposure sequencer
    st_type           st_r, st_nxt;
    logic [EXP_W-1:0] cnt_r, cnt_nxt;
    logic [EXP_W-1:0] len_r, len_nxt;
    logic [DLY_W-1:0] dly_r, dly_nxt;
    logic             start_nxt, end_nxt, start_r, end_r;

    always_comb
    begin
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        len_nxt   = len_r;
        dly_nxt   = dly_r;
        start_nxt = 1'b0;
        end_nxt   = 1'b0;
        case (st_r)
            ST_IDLE:
            begin
                if (trig_ev)
                begin
                    // Latch length now so a live change never cuts a frame
                    len_nxt = exp_live;
                    if (frame_valid)
                        st_nxt = ST_ALIGN;
                    else
                    begin
                        st_nxt  = ST_DELAY;
                        dly_nxt = DLY_W'(START_DELAY_CYC);
                    end
                end
            end
            ST_ALIGN:
            begin
                if (lv_fall)
                begin
                    st_nxt    = ST_EXPOSE;
                    cnt_nxt   = len_r;
                    start_nxt = 1'b1;
                end
            end
            ST_DELAY:
            begin
                // Fixed count, independent of line timing
                if (dly_r <= DLY_W'(1))
                begin
                    st_nxt    = ST_EXPOSE;
                    cnt_nxt   = len_r;
                    start_nxt = 1'b1;
                end
                else
                    dly_nxt = dly_r - DLY_W'(1);
            end
            ST_EXPOSE:
            begin
                // Triggers are not looked at here
                if (cnt_r <= EXP_W'(1))
                begin
                    st_nxt  = ST_IDLE;
                    end_nxt = 1'b1;
                end
                cnt_nxt = cnt_r - EXP_W'(1);
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            st_r    <= ST_IDLE;
            cnt_r   <= '0;
            len_r   <= EXP_RESET;
            dly_r   <= '0;
            start_r <= 1'b0;
            end_r   <= 1'b0;
        end
        else
        begin
            st_r    <= st_nxt;
            cnt_r   <= cnt_nxt;
            len_r   <= len_nxt;
            dly_r   <= dly_nxt;
            start_r <= start_nxt;
            end_r   <= end_nxt;
        end
    end

    assign exposure_active = (st_r == ST_EXPOSE);
    assign exposure_start  = start_r;
    assign exposure_end    = end_r;
    assign waiting_trigger = (st_r == ST_IDLE) && acq_enable;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [EXP_W-1:0] run_r;

    // Cycles spent exposing, for the length check
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || st_r != ST_EXPOSE)
            run_r <= '0;
        else
            run_r <= run_r + EXP_W'(1);
    end

    no_spont_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        st_r == ST_IDLE && !trig_ev |=> st_r == ST_IDLE) else $error("capture without trigger");
    exp_length_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $fell(exposure_active) |-> run_r == len_r) else $error("exposure length wrong");
    default_input_a: assert property (@(posedge ref_clk)
        $past(sys_rst) && !sys_rst |-> insel_r == 2'h0 && src_r == SRC_HARDWARE) else $error("bad default input");
    hw_edge_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        st_r == ST_IDLE && src_r == SRC_HARDWARE && acq_enable && hw_rise[insel_r]
        |=> st_r != ST_IDLE) else $error("hardware edge missed");
    align_fall_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(exposure_active) && $past(st_r) == ST_ALIGN
        |-> $past(lv_fall)) else $error("start not on line fall");
    // Start pulse is registered, so it shows one edge after the count ends
    idle_delay_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        st_r == ST_IDLE && trig_ev && !frame_valid |=> ##10 exposure_start) else $error("fixed delay wrong");
    len_stable_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        st_r != ST_IDLE |=> $stable(len_r)) else $error("length changed mid frame");
    ignore_trig_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        exposure_active && cnt_r > EXP_W'(1) |=> exposure_active) else $error("exposure cut short");
    src_set_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        src_we && src_sel != 2'h3 |=> src_r == $past(src_sel)) else $error("source write lost");

    overlap_c: cover property (@(posedge ref_clk) st_r == ST_ALIGN ##[1:200] exposure_start);
    idle_c:    cover property (@(posedge ref_clk) st_r == ST_DELAY ##[1:20] exposure_start);
    timed_c:   cover property (@(posedge ref_clk) src_r == SRC_TIMED && exposure_start);
    hw_c:      cover property (@(posedge ref_clk) src_r == SRC_HARDWARE && exposure_start);
    ignored_c: cover property (@(posedge ref_clk) exposure_active && sw_trigger);
endmodule
`default_nettype wire

// *** verification/test_trigger_exposure_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_trigger_exposure_control;
    import trig_exp_pkg::*;

    logic                ref_clk = 1'b0;
    logic                sys_rst = 1'b1;
    logic                sw_trigger = 1'b0;
    logic [1:0]          src_sel = 2'h0;
    logic                src_we = 1'b0;
    logic [IN_SEL_W-1:0] in_sel = '0;
    logic                in_sel_we = 1'b0;
    logic [TIMER_W-1:0]  timer_period = '0;
    logic                timer_we = 1'b0;
    logic                acq_enable = 1'b1;
    logic [EXP_W-1:0]    cfg_exp = '0;
    logic                cfg_exp_we = 1'b0;
    logic                save_req = 1'b0;
    logic                nv_valid = 1'b0;
    logic [EXP_W-1:0]    nv_exp = '0;
    logic [IN_COUNT-1:0] trigger_in;
    logic                frame_valid;
    logic                line_valid;
    logic                nv_we;
    logic [EXP_W-1:0]    nv_wdata;
    logic                exposure_active;
    logic                exposure_start;
    logic                exposure_end;
    logic                waiting_trigger;
    int                  errors = 0;
    int                  cmp_count = 0;
    int                  dly;
    int                  len;

    always #50 ref_clk = ~ref_clk;

    trig_src_model u_trig_src_model (.ref_clk(ref_clk), .trigger_in(trigger_in), .frame_valid(frame_valid),
        .line_valid(line_valid));

    trigger_exposure_control u_trigger_exposure_control (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .trigger_in(trigger_in), .sw_trigger(sw_trigger), .src_sel(src_sel), .src_we(src_we),
        .in_sel(in_sel), .in_sel_we(in_sel_we), .timer_period(timer_period), .timer_we(timer_we),
        .acq_enable(acq_enable), .cfg_exp(cfg_exp), .cfg_exp_we(cfg_exp_we), .save_req(save_req),
        .nv_valid(nv_valid), .nv_exp(nv_exp), .frame_valid(frame_valid), .line_valid(line_valid),
        .nv_we(nv_we), .nv_wdata(nv_wdata), .exposure_active(exposure_active),
        .exposure_start(exposure_start), .exposure_end(exposure_end), .waiting_trigger(waiting_trigger));

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int v, input int lo, input int hi);
        cmp_count++;
        if (v < lo || v > hi)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h to %h", $time, v, lo, hi);
        end
    endtask

    task automatic do_rst;
        sys_rst = 1'b1;
        repeat (5) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
    endtask

    // One strobe write; k picks source, input, period, exposure
    task automatic cfg(input int k, input logic [31:0] v);
        @(posedge ref_clk);
        #1;
        src_sel      = v[1:0];
        in_sel       = v[IN_SEL_W-1:0];
        timer_period = v;
        cfg_exp      = v;
        src_we       = (k == 0);
        in_sel_we    = (k == 1);
        timer_we     = (k == 2);
        cfg_exp_we   = (k == 3);
        @(posedge ref_clk);
        #1;
        {src_we, in_sel_we, timer_we, cfg_exp_we} = '0;
    endtask

    task automatic kick;
        @(posedge ref_clk);
        #1;
        sw_trigger = 1'b1;
    endtask

    // No exposure activity for n cycles
    task automatic quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n)
        begin
            @(posedge ref_clk);
            #1;
            sw_trigger = 1'b0;
            seen = seen | exposure_active | exposure_start;
        end
        chk(seen, 1'b0);
    endtask

    // Edges to start, then cycles high; poke re-triggers and writes mid-exposure
    task automatic measure(input int bound, input int poke);
        dly = 0;
        len = 0;
        while (exposure_start !== 1'b1)
        begin
            @(posedge ref_clk);
            #1;
            sw_trigger = 1'b0;
            dly++;
            if (dly > bound)
            begin
                chk(32'h0, 32'h1);
                end_sim;
            end
        end
        while (exposure_active === 1'b1 && len < 20000)
        begin
            len++;
            if (len == poke)
            begin
                sw_trigger = 1'b1;
                cfg_exp_we = 1'b1;
            end
            @(posedge ref_clk);
            #1;
            if (len == poke)
            begin
                sw_trigger = 1'b0;
                cfg_exp_we = 1'b0;
            end
        end
        if (exposure_active === 1'b1)
        begin
            chk(32'h0, 32'h1);
            end_sim;
        end
        chk(exposure_end, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_hw;
        chk(waiting_trigger, 1'b1);
        kick;
        quiet(40);
        u_trig_src_model.pin_set(1, 1'b1);
        quiet(40);
        u_trig_src_model.pin_set(0, 1'b1);
        measure(40, 0);
        chk_rng(dly, START_DELAY_CYC + 4, START_DELAY_CYC + 6);
        chk(len, EXP_RESET);
        quiet(40);
        u_trig_src_model.pin_set(0, 1'b0);
        u_trig_src_model.pin_set(1, 1'b0);
        cfg(1, 32'h1);
        u_trig_src_model.pin_set(1, 1'b1);
        measure(40, 0);
        u_trig_src_model.pin_set(1, 1'b0);
        $display("test hw done");
    endtask

    task automatic t_sw;
        cfg(0, 32'h0);
        cfg(0, 32'h3);
        acq_enable = 1'b0;
        kick;
        quiet(30);
        chk(waiting_trigger, 1'b0);
        acq_enable = 1'b1;
        cfg_exp = 32'h0000_02bc;
        kick;
        measure(30, 100);
        chk(dly, START_DELAY_CYC + 1);
        chk(len, EXP_RESET);
        quiet(20);
        kick;
        measure(30, 0);
        chk(len, 32'h0000_02bc);
        cfg(3, 32'h0000_0005);
        kick;
        measure(30, 0);
        chk(len, EXP_MIN_CYC);
        cfg(3, 32'h0000_02bc);
        $display("test sw done");
    endtask

    task automatic t_ovl;
        u_trig_src_model.frame(1'b1);
        kick;
        quiet(30);
        u_trig_src_model.line_end;
        measure(10, 0);
        chk_rng(dly, 1, 3);
        u_trig_src_model.frame(1'b0);
        $display("test overlap done");
    endtask

    task automatic t_nv;
        @(posedge ref_clk);
        #1;
        save_req = 1'b1;
        @(posedge ref_clk);
        #1;
        save_req = 1'b0;
        chk(nv_we, 1'b1);
        chk(nv_wdata, 32'h0000_02bc);
        nv_valid = 1'b1;
        nv_exp   = 32'h0000_0320;
        do_rst;
        cfg(0, 32'h0);
        kick;
        measure(30, 0);
        chk(len, 32'h0000_0320);
        $display("test store done");
    endtask

    task automatic t_timed;
        cfg(2, 32'h0000_0bb8);
        cfg(0, 32'h2);
        measure(3100, 0);
        measure(3100, 0);
        chk_rng(dly, 2000, 3000);
        $display("test timed done");
    endtask

    initial
    begin
        do_rst;
        t_hw;
        t_sw;
        t_ovl;
        t_nv;
        t_timed;
        end_sim;
    end
endmodule
`default_nettype wire

// *** verification/trig_src_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module trig_src_model
    import trig_exp_pkg::*;
(
    input  wire logic                ref_clk,     // Core clock
    output logic      [IN_COUNT-1:0] trigger_in,  // Trigger pin levels
    output logic                     frame_valid, // Readout frame level
    output logic                     line_valid   // Readout line level
);
    initial
    begin
        trigger_in  = '0;
        frame_valid = 1'b0;
        line_valid  = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pins are async to the core; level may stay high far past the edge
    task automatic pin_set(input int idx, input logic v);
        @(posedge ref_clk);
        #1;
        trigger_in[idx] = v;
    endtask

    // Readout held mid-line until the bench ends the line
    task automatic frame(input logic v);
        @(posedge ref_clk);
        #1;
        frame_valid = v;
        line_valid  = v;
    endtask

    task automatic line_end;
        @(posedge ref_clk);
        #1;
        line_valid = 1'b0;
    endtask
endmodule
`default_nettype wire
